//--- inc/anx_pkg.sv
// Package for the auto-negotiation next-page and expansion status bank.
// Assumes one core clock and a management core that issues single-cycle read strobes.
package anx_pkg;

  // ==========================================================================
  // Register map.
  localparam logic [4:0] ANX_ADDR_PARTNER_NP = 5'h05;
  localparam logic [4:0] ANX_ADDR_EXPANSION  = 5'h06;

  // ==========================================================================
  // Field positions of the received next-page word.
  localparam int ANX_NP_BIT_NEXT   = 15;
  localparam int ANX_NP_BIT_ACK    = 14;
  localparam int ANX_NP_BIT_MP     = 13;
  localparam int ANX_NP_BIT_PARTNER_CAN_COMPLY   = 12;
  localparam int ANX_NP_BIT_TOGGLE = 11;
  localparam int ANX_NP_CODE_MSB   = 10;
  localparam int ANX_CODE_W        = 11;

  // ==========================================================================
  // Field positions of the expansion status register.
  localparam int ANX_EXP_RSVD_LSB  = 5;
  localparam int ANX_EXP_BIT_PDF   = 4;
  localparam int ANX_EXP_BIT_LPNP  = 3;
  localparam int ANX_EXP_BIT_NP    = 2;
  localparam int ANX_EXP_BIT_PGRX  = 1;
  localparam int ANX_EXP_BIT_LPAN  = 0;

  // ==========================================================================
  // Values after reset.
  localparam logic [10:0] ANX_CODE_RST     = 11'h000;
  localparam logic        ANX_FLAG_RST     = 1'b0;
  localparam logic        ANX_LOCAL_NP_VAL = 1'b1;
  localparam logic [15:0] ANX_RDATA_RST    = 16'h0000;
  localparam logic [10:0] ANX_EXP_RSVD_VAL = 11'h000;

  // ==========================================================================
  // Received next-page ability word as held in the bank.
  typedef struct packed {
    logic        next_page;
    logic        partner_ack;
    logic        message_page_flag;
    logic        partner_can_comply;
    logic        toggle;
    logic [10:0] code;
  } anx_np_word_t;

  // Partner status levels from the negotiation logic.
  typedef struct packed {
    logic parallel_detect_fault;
    logic partner_next_page_capable;
    logic partner_autoneg_capable;
  } anx_status_t;

endpackage

//--- rtl/anx_status_bank.sv
// Auto-negotiation partner next-page word and expansion status register bank.
// Assumes the negotiation logic and the management core share REF_CLK with this bank.
`timescale 1ns/1ps
`default_nettype none

module anx_status_bank
  import anx_pkg::*;
#(
  parameter int ADDR_W = 5
) (
  // Clock and reset.
  input  wire logic               REF_CLK,
  input  wire logic               RST,
  // Management read port, one-cycle strobe per completed read.
  input  wire logic               REG_RD,
  input  wire logic [ADDR_W-1:0]  REG_ADDR,
  output var  logic               REG_RVALID,
  output var  logic [15:0]        REG_RDATA,
  // Negotiation logic events and levels.
  input  wire logic               AN_PAGE_VALID,
  input  wire anx_np_word_t       AN_PAGE_WORD,
  input  wire logic               AN_ACK_SET,
  input  wire logic               AN_ACK_CLR,
  input  wire logic               AN_TX_TOGGLE,
  input  wire anx_status_t        AN_STATUS,
  // Page-received flag as seen by the negotiation logic.
  output var  logic               PAGE_RX
);

  // ==========================================================================
  // Elaboration checks.
  if (ADDR_W != 5) begin : g_bad_addr_w
    $error("anx_status_bank: ADDR_W must be 5");
  end

  // ==========================================================================
  // State.
  anx_np_word_t np_word;
  anx_np_word_t page_q;
  logic         ack_q;
  logic         toggle_q;
  anx_status_t  status;
  logic         page_rx;
  logic         read_exp;
  logic [15:0]  next_rdata;

  assign read_exp = REG_RD && (REG_ADDR == ANX_ADDR_EXPANSION);
  assign PAGE_RX  = page_rx;

  // Each field has one owner process; the word is only assembled here.
  assign np_word = {page_q.next_page,
                    ack_q,
                    page_q.message_page_flag,
                    page_q.partner_can_comply,
                    toggle_q,
                    page_q.code};

  // Acknowledge belongs to the negotiation logic; there is no write path to it.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      ack_q <= ANX_FLAG_RST;
    end else if (AN_ACK_SET) begin
      ack_q <= 1'b1;
    end else if (AN_ACK_CLR) begin
      ack_q <= 1'b0;
    end
  end

  // Page fields are captured whole so software never sees a mix of two pages.
  // The acknowledge and toggle positions of the copy are never shown.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      page_q <= '0;
    end else if (AN_PAGE_VALID) begin
      page_q <= AN_PAGE_WORD;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      toggle_q <= ANX_FLAG_RST;
    end else begin
      toggle_q <= ~AN_TX_TOGGLE;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      status <= '0;
    end else begin
      status <= AN_STATUS;
    end
  end

  // A page arriving in the read cycle must not be lost, so set outranks clear.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      page_rx <= ANX_FLAG_RST;
    end else if (AN_PAGE_VALID) begin
      page_rx <= 1'b1;
    end else if (read_exp) begin
      page_rx <= 1'b0;
    end
  end

  // ==========================================================================
  // Read data. Unknown addresses answer zero; writes have no effect anywhere.
  always_comb begin
    next_rdata = ANX_RDATA_RST;
    if (REG_ADDR == ANX_ADDR_PARTNER_NP) begin
      next_rdata = np_word;
    end else if (REG_ADDR == ANX_ADDR_EXPANSION) begin
      next_rdata = {ANX_EXP_RSVD_VAL,
                    status.parallel_detect_fault,
                    status.partner_next_page_capable,
                    ANX_LOCAL_NP_VAL,
                    page_rx,
                    status.partner_autoneg_capable};
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      REG_RVALID <= 1'b0;
      REG_RDATA  <= ANX_RDATA_RST;
    end else begin
      REG_RVALID <= REG_RD;
      if (REG_RD) begin
        REG_RDATA <= next_rdata;
      end
    end
  end

  // ==========================================================================
  // Assertions.
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  a_ack_set_wins: assert property (
    AN_ACK_SET |=> np_word.partner_ack)
    else $error("Acknowledge not set after set event.");

  a_ack_clear: assert property (
    (AN_ACK_CLR && !AN_ACK_SET) |=> !np_word.partner_ack)
    else $error("Acknowledge not cleared after clear event.");

  a_page_capture: assert property (
    AN_PAGE_VALID |=> (np_word.message_page_flag == $past(AN_PAGE_WORD.message_page_flag))
      && (np_word.partner_can_comply == $past(AN_PAGE_WORD.partner_can_comply))
      && (np_word.code == $past(AN_PAGE_WORD.code)))
    else $error("Received page fields not captured.");

  a_page_hold: assert property (
    !AN_PAGE_VALID |=> $stable(np_word.code) && $stable(np_word.message_page_flag))
    else $error("Page fields changed without a new page.");

  a_toggle_inverse: assert property (
    ##1 np_word.toggle == !$past(AN_TX_TOGGLE))
    else $error("Toggle is not the inverse of the sent toggle.");

  a_exp_fixed_bits: assert property (
    (REG_RD && REG_ADDR == ANX_ADDR_EXPANSION) |=> REG_RVALID
      && REG_RDATA[15:ANX_EXP_RSVD_LSB] == ANX_EXP_RSVD_VAL && REG_RDATA[ANX_EXP_BIT_NP])
    else $error("Expansion reserved or local next-page bits wrong.");

  a_exp_status: assert property (
    (REG_RD && REG_ADDR == ANX_ADDR_EXPANSION) |=>
      REG_RDATA[ANX_EXP_BIT_PDF] == $past(status.parallel_detect_fault, 1)
      && REG_RDATA[ANX_EXP_BIT_LPNP] == $past(status.partner_next_page_capable, 1)
      && REG_RDATA[ANX_EXP_BIT_LPAN] == $past(status.partner_autoneg_capable, 1))
    else $error("Expansion status bits do not match partner state.");

  a_status_follow: assert property (
    ##1 status == $past(AN_STATUS))
    else $error("Partner status not tracked.");

  a_page_rx_set: assert property (
    AN_PAGE_VALID |=> page_rx)
    else $error("Page-received flag lost a new page.");

  a_page_rx_clear: assert property (
    (read_exp && !AN_PAGE_VALID) |=> !page_rx ##0 REG_RDATA[ANX_EXP_BIT_PGRX] == $past(page_rx))
    else $error("Page-received flag not cleared by read.");

  a_page_rx_sticky: assert property (
    (page_rx && !read_exp) |=> page_rx)
    else $error("Page-received flag dropped without a read.");

  a_np_read: assert property (
    (REG_RD && REG_ADDR == ANX_ADDR_PARTNER_NP) |=> REG_RDATA == $past(np_word))
    else $error("Next-page word read returned wrong data.");

endmodule // anx_status_bank

`default_nettype wire

//--- testbench/anx_mgmt_model.sv
// Management controller model that issues register reads to the status bank.
// Assumes the bank registers its answer on the edge that takes the strobe, so it can be read one cycle later.
`timescale 1ns/1ps
`default_nettype none

module anx_mgmt_model (
  // Clock.
  input  wire logic        REF_CLK,
  // Read strobe toward the bank.
  output var  logic        REG_RD,
  output var  logic [4:0]  REG_ADDR,
  // Answer from the bank.
  input  wire logic        REG_RVALID,
  input  wire logic [15:0] REG_RDATA
);
  initial begin
    REG_RD   = 1'b0;
    REG_ADDR = 5'h00;
  end

  // ==========================================================================
  // Read access.
  // There is no write path, so the acknowledge flag is never written.
  task automatic read(input logic [4:0] a, output logic [15:0] d, output logic ok);
    @(posedge REF_CLK);
    REG_RD   <= 1'b1;
    REG_ADDR <= a;
    @(posedge REF_CLK);
    REG_RD   <= 1'b0;
    // A released address shows a changed pattern so stale values cannot match.
    REG_ADDR <= ~a;
    // The answer stands from the strobe edge to the next one; take it there.
    @(posedge REF_CLK);
    ok = (REG_RVALID === 1'b1);
    d  = REG_RDATA;
  endtask
endmodule // anx_mgmt_model

`default_nettype wire

//--- testbench/tb_anx_status_bank.sv
// Self-checking bench for the next-page and expansion status bank.
// Assumes the management model in anx_mgmt_model.sv drives the read port.
`timescale 1ns/1ps
`default_nettype none

module tb_anx_status_bank
  import anx_pkg::*;
;
  logic         clk = 1'b0, rst = 1'b1, pg_v = 1'b0, a_set = 1'b0, a_clr = 1'b0, tx_tog = 1'b1;
  logic         rd, rvalid, page_rx;
  logic [4:0]   addr;
  logic [15:0]  rdata;
  anx_np_word_t pg_w = '0;
  anx_status_t  st = '0;
  int           errors = 0, n_checks = 0, cyc = 0;

  always #5 clk = ~clk;

  anx_status_bank u_anx_status_bank (.REF_CLK(clk), .RST(rst), .REG_RD(rd), .REG_ADDR(addr),
    .REG_RVALID(rvalid), .REG_RDATA(rdata), .AN_PAGE_VALID(pg_v), .AN_PAGE_WORD(pg_w),
    .AN_ACK_SET(a_set), .AN_ACK_CLR(a_clr), .AN_TX_TOGGLE(tx_tog), .AN_STATUS(st),
    .PAGE_RX(page_rx));
  anx_mgmt_model u_anx_mgmt_model (.REF_CLK(clk), .REG_RD(rd), .REG_ADDR(addr),
    .REG_RVALID(rvalid), .REG_RDATA(rdata));

  // ==========================================================================
  // Compare, access and stimulus tasks.
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %0t word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
    logic [15:0] d;
    logic        ok;
    u_anx_mgmt_model.read(a, d, ok);
    chk1(ok, 1'b1);
    chk16(d, exp);
  endtask
  task automatic page(input anx_np_word_t w);
    @(posedge clk);
    pg_v <= 1'b1;
    pg_w <= w;
    @(posedge clk);
    pg_v <= 1'b0;
    #1;
  endtask
  task automatic pulse(input logic s, input logic c);
    @(posedge clk);
    a_set <= s;
    a_clr <= c;
    @(posedge clk);
    a_set <= 1'b0;
    a_clr <= 1'b0;
  endtask
  function automatic logic [15:0] ex6(input logic [2:0] s, input logic p);
    return {11'h000, s[2], s[1], 1'h1, p, s[0]};
  endfunction
  task automatic summarize();
    if (errors == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // A hung handshake must not stall the run; the whole sequence needs under 200 cycles.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      errors++;
      summarize();
    end
  end

  // ==========================================================================
  // Main sequence.
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    chk1(page_rx, 1'b0);
    rd_chk(ANX_ADDR_PARTNER_NP, 16'h0000);
    rd_chk(ANX_ADDR_EXPANSION, 16'h0004);
    page(16'hF5A5);
    chk1(page_rx, 1'b1);
    rd_chk(ANX_ADDR_PARTNER_NP, 16'hB5A5);
    rd_chk(ANX_ADDR_EXPANSION, 16'h0006);
    rd_chk(ANX_ADDR_EXPANSION, 16'h0004);
    pulse(1'b1, 1'b1);
    rd_chk(ANX_ADDR_PARTNER_NP, 16'hF5A5);
    pulse(1'b0, 1'b1);
    tx_tog <= 1'b0;
    rd_chk(ANX_ADDR_PARTNER_NP, 16'hBDA5);
    page(16'h07FF);
    rd_chk(ANX_ADDR_PARTNER_NP, 16'h0FFF);
    rd_chk(ANX_ADDR_EXPANSION, 16'h0006);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      st <= anx_status_t'(i[2:0]);
      rd_chk(ANX_ADDR_EXPANSION, ex6(i[2:0], 1'b0));
    end
    fork
      page(16'h8001);
      rd_chk(ANX_ADDR_EXPANSION, 16'h001D);
    join
    chk1(page_rx, 1'b1);
    rd_chk(5'h1F, 16'h0000);
    rd_chk(ANX_ADDR_EXPANSION, 16'h001F);
    summarize();
  end
endmodule // tb_anx_status_bank

`default_nettype wire
